/* File: hdl/acs_map.svh */
/*
  register offsets, field positions, reset values and timing counts
  of the conversion sequencer.
  assumes: included by bare name; word-aligned apb byte addresses.
*/
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define ACS_OFF_NCTRL 8'h00
`define ACS_OFF_MODE 8'h04
`define ACS_OFF_PCTRL 8'h08
`define ACS_OFF_PCH 8'h0c
// result pairs: 2'b01 in addr[7:6], pair in addr[5:3], high in addr[2]
`define ACS_RES_PAGE 2'h1
`define ACS_PAIRS 7
`define ACS_PRIO_PAIR 3'h6
// ****************************************
// normal_control_reg fields
// ****************************************
`define ACS_NC_START 0
`define ACS_NC_TSEL 2:1
`define ACS_NC_HWEN 3
`define ACS_NC_IDLE 4
`define ACS_NC_BUSY 6
`define ACS_NC_EOS 7
// ****************************************
// mode_select_reg fields
// ****************************************
`define ACS_MD_CH 2:0
`define ACS_MD_SCAN 3
`define ACS_MD_REP 4
`define ACS_MD_ITM 5
// ****************************************
// priority_control_reg fields
// ****************************************
`define ACS_PC_START 0
`define ACS_PC_TSEL 2:1
`define ACS_PC_HWEN 3
`define ACS_PC_BUSY 6
`define ACS_PC_EOS 7
// ****************************************
// trigger selections and reset values
// ****************************************
`define ACS_TSEL_TIMER 2'h0
`define ACS_TSEL_PIN 2'h2
`define ACS_TSEL_AUDIO 2'h3
`define ACS_RST_CH 3'h0
`define ACS_RST_TSEL 2'h1
`define ACS_LAST_CH 3'h5
// ****************************************
// timing
// ****************************************
`define ACS_CONV_CLOCKS 7'd120
`endif

/* File: hdl/acs_pkg.sv */
/*
  types shared by the conversion sequencer.
  assumes: nothing beyond a systemverilog compiler.
*/
package acs_pkg;
  // who currently owns the analog converter
  typedef enum logic [1:0] {
    OWN_IDLE,
    OWN_NORMAL,
    OWN_PRIO
  } owner_type;
endpackage

/* File: hdl/acs_sequencer.sv */
/*
  conversion sequencer for a six-input converter, apb register slave.
  assumes: analog core converts conv_channel while conv_active and
  shows a valid adc_result in the cycle a conversion completes;
  trigger pulses and standby levels are on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.svh"
module acs_sequencer #(
  parameter int CONV_DIV = 4 // ref_clk cycles per conversion clock
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin_n,
  input wire logic timer0_match_interrupt,
  input wire logic timer1_match_interrupt,
  input wire logic audio_sample_event,
  input wire logic first_idle_mode,
  input wire logic second_idle_mode,
  input wire logic stop_mode,
  input wire logic [9:0] adc_result,
  output logic conv_active,
  output logic [2:0] conv_channel,
  output logic normal_end_interrupt,
  output logic priority_end_interrupt
);
  // ****************************************
  // elaboration checks
  // ****************************************
  localparam int DIV_W = (CONV_DIV > 1) ? $clog2(CONV_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
  if (CONV_DIV < 1) begin : g_chk
    $error("CONV_DIV must be at least 1");
  end

  // ****************************************
  // state
  // ****************************************
  logic [1:0] ntsel_reg; // normal trigger select
  logic nhwen_reg; // normal hardware trigger enable
  logic idle_run_reg; // keep running in second idle mode
  logic eos_reg; // normal end flag
  logic [2:0] nfield_reg; // normal channel field
  logic scan_reg;
  logic rep_reg;
  logic itm_reg; // interrupt timing bit
  logic [1:0] ptsel_reg;
  logic phwen_reg;
  logic priority_end_flag_reg; // priority end flag
  logic [2:0] pfield_reg; // priority channel field
  logic nbusy_reg; // normal sequence in progress
  logic nbusy_next;
  logic pbusy_reg; // priority conversion in progress
  logic pbusy_next;
  logic [2:0] nch_reg; // channel of the normal sequence
  logic [2:0] nch_next;
  logic [1:0] fill_reg; // store slot in fixed repeat, four slots
  logic [1:0] fill_next;
  logic [6:0] cnt_reg; // conversion clocks spent
  logic [DIV_W-1:0] div_reg; // conversion clock divider
  logic [9:0] res_reg [0:6]; // result pairs, pair 6 is priority
  logic rf_reg [0:6]; // result stored flags
  logic ovr_reg [0:6]; // overrun flags
  logic hrd_reg [0:6]; // high byte read since last store
  logic lrd_reg [0:6]; // low byte read since last store
  logic [2:0] sync_reg; // trigger pin synchroniser
  logic pin_reg; // filtered pin level
  logic fall_reg; // one-cycle falling edge pulse
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic active_reg;
  logic [2:0] chan_reg;
  logic nirq_reg;
  logic pirq_reg;
  acs_pkg::owner_type owner_reg; // converter owner, gates the conversion timer
  acs_pkg::owner_type owner_next;

  // ****************************************
  // apb decode
  // ****************************************
  wire acc = psel & penable;
  // read data is captured in the first access cycle; writes land with the answer the next
  wire cap = acc & ~pready_reg;
  wire wr_en = acc & pready_reg & pwrite;
  wire rd_cap = cap & ~pwrite;
  wire hit_nc = paddr == `ACS_OFF_NCTRL;
  wire hit_md = paddr == `ACS_OFF_MODE;
  wire hit_pc = paddr == `ACS_OFF_PCTRL;
  wire hit_ph = paddr == `ACS_OFF_PCH;
  wire [2:0] pidx = paddr[5:3];
  wire hit_rs = (paddr[7:6] == `ACS_RES_PAGE) && (pidx != 3'h7);
  wire hi_sel = paddr[2];
  wire [1:0] low_bits = paddr[1:0];
  wire mapped = (hit_nc | hit_md | hit_pc | hit_ph | hit_rs) && (low_bits == 2'h0);
  // read side effects act at the capture edge so a set in that
  // very cycle still shows in a later read
  wire rd_nc = rd_cap & hit_nc;
  wire rd_pc = rd_cap & hit_pc;
  wire rd_lo = rd_cap & hit_rs & ~hi_sel;
  wire rd_hi = rd_cap & hit_rs & hi_sel;

  // ****************************************
  // trigger sources
  // ****************************************
  wire tmr_n = ntsel_reg == `ACS_TSEL_TIMER;
  wire pin_n = ntsel_reg == `ACS_TSEL_PIN;
  wire tmr_p = ptsel_reg == `ACS_TSEL_TIMER;
  wire pin_p = ptsel_reg == `ACS_TSEL_PIN;
  wire aud_p = ptsel_reg == `ACS_TSEL_AUDIO;
  wire n_src = (pin_n & fall_reg) | (tmr_n & timer0_match_interrupt);
  wire p_src = (pin_p & fall_reg) | (tmr_p & timer1_match_interrupt) | (aud_p & audio_sample_event);
  wire sw_n = wr_en & hit_nc & pwdata[`ACS_NC_START];
  wire sw_p = wr_en & hit_pc & pwdata[`ACS_PC_START];
  // software start is honoured whatever trigger is enabled
  wire n_start = sw_n | (nhwen_reg & n_src);
  wire p_req = sw_p | (phwen_reg & p_src);
  // halt in standby: second idle only when told not to run
  wire halt = first_idle_mode | stop_mode | (second_idle_mode & ~idle_run_reg);
  wire p_take = p_req & ~pbusy_reg & ~halt;

  // ****************************************
  // channel selection
  // ****************************************
  // field values above five fall back to the last input
  wire [2:0] clamp = (nfield_reg > `ACS_LAST_CH) ? `ACS_LAST_CH : nfield_reg;
  wire [2:0] first_ch = scan_reg ? 3'h0 : clamp;
  wire [2:0] pclamp = (pfield_reg > `ACS_LAST_CH) ? `ACS_LAST_CH : pfield_reg;
  wire fix_rep = rep_reg & ~scan_reg;
  wire four = fix_rep & itm_reg;
  wire pass_end = ~scan_reg | (nch_reg == clamp);
  wire tick = div_reg == DIV_LAST;
  wire conv_on = owner_reg != acs_pkg::OWN_IDLE;
  wire done = conv_on & tick & (cnt_reg == `ACS_CONV_CLOCKS - 7'd1);
  wire [2:0] nslot = four ? {1'b0, fill_reg} : nch_reg;

  // ****************************************
  // sequencer next state
  // ****************************************
  logic restart; // reopen the conversion counter
  logic store_n;
  logic store_p;
  logic eos_set;
  logic priority_end_flag_set;
  always_comb begin
    nbusy_next = nbusy_reg;
    pbusy_next = pbusy_reg;
    nch_next = nch_reg;
    fill_next = fill_reg;
    restart = 1'b0;
    store_n = 1'b0;
    store_p = 1'b0;
    eos_set = 1'b0;
    priority_end_flag_set = 1'b0;
    if (halt) begin
      // standby drops both sequences, even mid-conversion
      nbusy_next = 1'b0;
      pbusy_next = 1'b0;
      restart = 1'b1;
    end else begin
      if (done && pbusy_reg) begin
        // priority result, then the normal channel is redone
        store_p = 1'b1;
        priority_end_flag_set = 1'b1;
        pbusy_next = 1'b0;
        restart = 1'b1;
      end else if (done) begin
        store_n = 1'b1;
        restart = 1'b1;
        if (four) begin
          fill_next = fill_reg + 2'h1;
        end
        if (!pass_end) begin
          nch_next = nch_reg + 3'h1;
        end else begin
          eos_set = ~four | (fill_reg == 2'h3);
          nch_next = first_ch;
          // repeat bit is only looked at when a pass ends
          nbusy_next = rep_reg;
        end
      end
      if (n_start) begin
        // restart the sequence; a running priority keeps the core
        nbusy_next = 1'b1;
        nch_next = first_ch;
        fill_next = 2'h0;
        restart = restart | ~pbusy_next;
      end
      if (p_take) begin
        pbusy_next = 1'b1;
        restart = 1'b1;
      end
    end
  end

  always_comb begin
    owner_next = acs_pkg::OWN_IDLE;
    if (pbusy_next) begin
      owner_next = acs_pkg::OWN_PRIO;
    end else if (nbusy_next) begin
      owner_next = acs_pkg::OWN_NORMAL;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  wire [2:0] ridx = hit_rs ? pidx : 3'h0;
  wire [9:0] rres = res_reg[ridx];
  wire [31:0] nc_rd = {24'h0, eos_reg, nbusy_reg, 1'b0, idle_run_reg, nhwen_reg, ntsel_reg, 1'b0};
  wire [31:0] md_rd = {26'h0, itm_reg, rep_reg, scan_reg, nfield_reg};
  wire [31:0] pc_rd = {24'h0, priority_end_flag_reg, pbusy_reg, 2'h0, phwen_reg, ptsel_reg, 1'b0};
  wire [31:0] ph_rd = {29'h0, pfield_reg};
  wire [31:0] lo_rd = {24'h0, rres[1:0], 4'h0, ovr_reg[ridx], rf_reg[ridx]};
  wire [31:0] hi_rd = {24'h0, rres[9:2]};
  wire [31:0] rs_rd = hi_sel ? hi_rd : lo_rd;
  wire [31:0] rd_mux = !mapped ? 32'h0 : hit_nc ? nc_rd : hit_md ? md_rd :
                       hit_pc ? pc_rd : hit_ph ? ph_rd : rs_rd;

  // ****************************************
  // apb answer, one wait state
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= cap;
      pslverr_reg <= cap & ~mapped;
      if (rd_cap) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************
  // software control registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ntsel_reg <= `ACS_RST_TSEL;
      nhwen_reg <= 1'b0;
      idle_run_reg <= 1'b0;
      nfield_reg <= `ACS_RST_CH;
      scan_reg <= 1'b0;
      rep_reg <= 1'b0;
      itm_reg <= 1'b0;
      ptsel_reg <= `ACS_RST_TSEL;
      phwen_reg <= 1'b0;
      pfield_reg <= `ACS_RST_CH;
    end else begin
      if (wr_en && hit_nc) begin
        ntsel_reg <= pwdata[`ACS_NC_TSEL];
        nhwen_reg <= pwdata[`ACS_NC_HWEN];
        idle_run_reg <= pwdata[`ACS_NC_IDLE];
      end
      if (wr_en && hit_md) begin
        nfield_reg <= pwdata[`ACS_MD_CH];
        scan_reg <= pwdata[`ACS_MD_SCAN];
        rep_reg <= pwdata[`ACS_MD_REP];
        itm_reg <= pwdata[`ACS_MD_ITM];
      end
      if (wr_en && hit_pc) begin
        // select changes go straight through; software should
        // drop the enable first to avoid a stray start
        ptsel_reg <= pwdata[`ACS_PC_TSEL];
        phwen_reg <= pwdata[`ACS_PC_HWEN];
      end
      if (wr_en && hit_ph) begin
        pfield_reg <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // end flags, set wins over read clear
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      eos_reg <= 1'b0;
      priority_end_flag_reg <= 1'b0;
    end else begin
      eos_reg <= eos_set | (eos_reg & ~rd_nc);
      priority_end_flag_reg <= priority_end_flag_set | (priority_end_flag_reg & ~rd_pc);
    end
  end

  // ****************************************
  // sequencer and conversion timer
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nbusy_reg <= 1'b0;
      pbusy_reg <= 1'b0;
      nch_reg <= `ACS_RST_CH;
      fill_reg <= 2'h0;
      owner_reg <= acs_pkg::OWN_IDLE;
    end else begin
      nbusy_reg <= nbusy_next;
      pbusy_reg <= pbusy_next;
      nch_reg <= nch_next;
      fill_reg <= fill_next;
      owner_reg <= owner_next;
    end
  end

  // abort restarts the count from zero, no partial credit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= '0;
      cnt_reg <= 7'h0;
    end else if (restart || !conv_on) begin
      div_reg <= '0;
      cnt_reg <= 7'h0;
    end else if (tick) begin
      div_reg <= '0;
      cnt_reg <= cnt_reg + 7'h1;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  // ****************************************
  // result pairs with stored and overrun flags
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `ACS_PAIRS; i++) begin
        res_reg[i] <= 10'h0;
        rf_reg[i] <= 1'b0;
        ovr_reg[i] <= 1'b0;
        hrd_reg[i] <= 1'b1;
        lrd_reg[i] <= 1'b1;
      end
    end else begin
      for (int i = 0; i < `ACS_PAIRS; i++) begin
        logic wr_i;
        logic lo_i;
        wr_i = (store_n && (nslot == 3'(i))) || (store_p && (i == 6));
        lo_i = rd_lo && (pidx == 3'(i));
        if (wr_i) begin
          res_reg[i] <= adc_result;
        end
        rf_reg[i] <= wr_i | (rf_reg[i] & ~lo_i);
        ovr_reg[i] <= (wr_i & ~(hrd_reg[i] & lrd_reg[i])) | (ovr_reg[i] & ~lo_i);
        hrd_reg[i] <= ~wr_i & (hrd_reg[i] | (rd_hi && (pidx == 3'(i))));
        lrd_reg[i] <= ~wr_i & (lrd_reg[i] | lo_i);
      end
    end
  end

  // ****************************************
  // trigger pin synchroniser and edge
  // ****************************************
  // level accepted once second and third stage agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= 3'h7;
      pin_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], external_trigger_pin_n};
      if (sync_reg[1] == sync_reg[2]) begin
        pin_reg <= sync_reg[2];
      end
      fall_reg <= pin_reg & (sync_reg[1] == sync_reg[2]) & ~sync_reg[2];
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_reg <= 1'b0;
      chan_reg <= `ACS_RST_CH;
      nirq_reg <= 1'b0;
      pirq_reg <= 1'b0;
    end else begin
      active_reg <= nbusy_next | pbusy_next;
      chan_reg <= pbusy_next ? pclamp : nch_next;
      nirq_reg <= eos_set;
      pirq_reg <= priority_end_flag_set;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign conv_active = active_reg;
  assign conv_channel = chan_reg;
  assign normal_end_interrupt = nirq_reg;
  assign priority_end_interrupt = pirq_reg;
endmodule
`default_nettype wire

/* File: verification/acs_sequencer_sva.sv */
/* port checker for the conversion sequencer.
   assumes: one clock domain; the divider matches the bound dut. */
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_sva #(
  parameter int CONV_DIV = 4 // ref_clk cycles per conversion clock
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic first_idle_mode,
  input wire logic second_idle_mode,
  input wire logic stop_mode,
  input wire logic conv_active,
  input wire logic normal_end_interrupt,
  input wire logic priority_end_interrupt
);
  // ****
  // helper logic
  // ****
  wire logic wr_done = psel && penable && pready && pwrite; // write lands
  wire logic asleep = first_idle_mode || second_idle_mode || stop_mode;
  int run_len; // length of the latest busy run, held after it ends
  logic was_active; // conv_active one cycle ago
  // a counter instead of a long repetition keeps the tools fast
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_len <= 0;
      was_active <= 1'b0;
    end else begin
      if (conv_active) begin
        run_len <= was_active ? run_len + 1 : 1;
      end
      was_active <= conv_active;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // access phase: one wait state, then ready
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  a_ready_wait: assert property (psel && $rose(penable) |-> s_one_wait)
    else $error("ready not one cycle after access start");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_error_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_nend_pulse: assert property (normal_end_interrupt |=> !normal_end_interrupt)
    else $error("normal end pulse too long");
  a_pend_pulse: assert property (priority_end_interrupt |=> !priority_end_interrupt)
    else $error("priority end pulse too long");
  a_conv_length: assert property ((normal_end_interrupt || priority_end_interrupt)
    |-> run_len >= CONV_DIV * 120) else $error("conversion ended too early");
  a_halt_now: assert property (first_idle_mode || stop_mode |=> !conv_active)
    else $error("converter runs in standby");
  a_nstart_runs: assert property (wr_done && paddr == 8'h00 && pwdata[0] && !asleep
    |-> ##[1:3] conv_active) else $error("normal start did not run");
  a_pstart_runs: assert property (wr_done && paddr == 8'h08 && pwdata[0] && !asleep
    |-> ##[1:3] conv_active [*8]) else $error("priority start did not run");
endmodule
bind acs_sequencer acs_sequencer_sva #(.CONV_DIV(CONV_DIV)) u_sva (.ref_clk, .nrst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .first_idle_mode,
  .second_idle_mode, .stop_mode, .conv_active, .normal_end_interrupt,
  .priority_end_interrupt);
`default_nettype wire

/* File: verification/acs_analog_model.sv */
/* analog side of the converter: each conversion sees a value that
   encodes the input converted.
   assumes: conv_channel is steady while conv_active is high. */
`timescale 1ns/1ps
`default_nettype none
module acs_analog_model (
  input wire logic ref_clk,
  input wire logic conv_active,
  input wire logic [2:0] conv_channel,
  output logic [9:0] adc_result
);
  logic flip = 1'b0; // toggles every cycle
  // idle output changes each cycle so a stale sample cannot pass
  always @(posedge ref_clk) flip <= !flip;
  // upper byte reads back as the input number then 5'h12
  assign adc_result = conv_active ? {conv_channel, 7'h4b} : (flip ? 10'h2aa : 10'h155);
endmodule
`default_nettype wire

/* File: verification/tb.sv */
/* bench for the conversion sequencer: table of single conversions and scan passes,
   then restart, preemption, repeat, triggers, standby, overrun.
   assumes: analog model beside the dut, checker bound to it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****
  // signals and tables
  // ****
  typedef struct packed {logic [7:0] mode; logic [2:0] ch; logic [3:0] n;} acs_row_type;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic pready, pslverr, rd_err, conv_active, normal_end_interrupt, priority_end_interrupt;
  logic external_trigger_pin_n = 1'b1, timer0_match_interrupt = 1'b0;
  logic timer1_match_interrupt = 1'b0, audio_sample_event = 1'b0;
  logic first_idle_mode = 1'b0, second_idle_mode = 1'b0, stop_mode = 1'b0;
  logic [9:0] adc_result;
  logic [2:0] conv_channel;
  int fails = 0, comparisons = 0, cyc, tick = 0, t0;
  // mode word, last input converted, conversions in the pass
  acs_row_type rows [5] = '{'{8'h00, 3'h0, 4'h1}, '{8'h03, 3'h3, 4'h1},
    '{8'h07, 3'h5, 4'h1}, '{8'h0a, 3'h2, 4'h3}, '{8'h0d, 3'h5, 4'h6}};
  logic [7:0] rep_mode [3] = '{8'h11, 8'h31, 8'h19}; // repeat modes
  int rep_gap [3] = '{120, 480, 240}; // cycles between end pulses
  // control address, control word, source one-hot: timer0 pin timer1 audio
  logic [7:0] trg_addr [5] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h08};
  logic [7:0] trg_ctrl [5] = '{8'h08, 8'h0c, 8'h08, 8'h0c, 8'h0e};
  logic [3:0] trg_src [5] = '{4'h1, 4'h2, 4'h4, 4'h2, 4'h8};
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tick <= tick + 1;
  // divider of one keeps a conversion at 120 ref_clk cycles
  acs_sequencer #(.CONV_DIV(1)) dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .external_trigger_pin_n, .timer0_match_interrupt,
    .timer1_match_interrupt, .audio_sample_event, .first_idle_mode, .second_idle_mode,
    .stop_mode, .adc_result, .conv_active, .conv_channel, .normal_end_interrupt,
    .priority_end_interrupt);
  acs_analog_model analog (.ref_clk, .conv_active, .conv_channel, .adc_result);
  // ****
  // tasks
  // ****
  // one transfer, then an idle edge so no signal is set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no cycle count assumed here; the watchdog ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wt(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      fails++;
      $display("unexpected %s: expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_data);
  endtask
  // waits for an end pulse, cycles waited left in cyc
  task automatic wait_end(input logic prio, input int lim);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      cyc++;
    end while ((prio ? priority_end_interrupt : normal_end_interrupt) !== 1'b1 && cyc < lim);
    if (cyc >= lim) fails++;
  endtask
  // one-cycle source pulses; the pin is held low long enough to pass the filter
  task automatic fire(input logic [3:0] s);
    timer0_match_interrupt <= s[0];
    external_trigger_pin_n <= !s[1];
    timer1_match_interrupt <= s[2];
    audio_sample_event <= s[3];
    @(posedge ref_clk);
    {audio_sample_event, timer1_match_interrupt, timer0_match_interrupt} <= 3'h0;
    repeat (8) @(posedge ref_clk);
    external_trigger_pin_n <= 1'b1;
  endtask
  task automatic results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    results();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdchk("mode reset", 8'h04, 32'h0);
    rdchk("control reset", 8'h00, 32'h2);
    rdchk("priority reset", 8'h08, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rd_err});
    chk("unmapped data", 32'h0, rd_data);
    foreach (rows[i]) begin
      wt(8'h04, {24'h0, rows[i].mode});
      wt(8'h00, 32'h3);
      wait_end(1'b0, 1000);
      chk_rng("pass cycles", 120 * rows[i].n, 124 * rows[i].n + 4, cyc);
      rdchk("end flag", 8'h00, 32'h82);
      rdchk("end cleared", 8'h00, 32'h2);
      rdchk("result high", {2'h1, rows[i].ch, 3'h4}, {24'h0, rows[i].ch, 5'h12});
      rdchk("stored", {2'h1, rows[i].ch, 3'h0}, 32'hc1);
      rdchk("stored cleared", {2'h1, rows[i].ch, 3'h0}, 32'hc0);
    end
    // restart in mid-conversion; the first conversion is abandoned, one end pulse
    wt(8'h04, 32'h2);
    wt(8'h00, 32'h3);
    repeat (60) @(posedge ref_clk);
    wt(8'h00, 32'h3);
    wait_end(1'b0, 1000);
    chk_rng("restart cycles", 119, 124, cyc);
    rdchk("single end flag", 8'h00, 32'h82);
    // priority preempts a normal conversion on input 1
    wt(8'h0c, 32'h4);
    wt(8'h04, 32'h1);
    wt(8'h00, 32'h3);
    repeat (40) @(posedge ref_clk);
    wt(8'h08, 32'h3);
    t0 = tick;
    chk("priority input", 32'h4, {29'h0, conv_channel});
    rdchk("normal busy kept", 8'h00, 32'h42);
    rdchk("priority busy", 8'h08, 32'h42);
    wt(8'h08, 32'h3);
    wait_end(1'b1, 1000);
    chk_rng("priority cycles", 118, 126, tick - t0);
    wait_end(1'b0, 1000);
    chk_rng("resumed cycles", 118, 126, cyc);
    rdchk("priority high", 8'h74, 32'h92);
    rdchk("resumed high", 8'h4c, 32'h32);
    // repeat modes, then repeat cleared
    for (int i = 0; i < 3; i++) begin
      wt(8'h04, {24'h0, rep_mode[i]});
      wt(8'h00, 32'h3);
      wait_end(1'b0, 2000);
      wait_end(1'b0, 2000);
      chk_rng("repeat gap", rep_gap[i], rep_gap[i] + 3, cyc);
      if (i == 1) rdchk("fourth slot", 8'h5c, 32'h32);
      wt(8'h04, {24'h0, rep_mode[i] & 8'hef});
      repeat (600) @(posedge ref_clk);
      chk("repeat ended", 32'h0, {31'h0, conv_active});
    end
    wt(8'h04, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wt(trg_addr[i], {24'h0, trg_ctrl[i]});
      if (trg_addr[i] == 8'h00) begin
        wt(8'h00, {24'h0, trg_ctrl[i] | 8'h01});
        chk("software start", 32'h1, {31'h0, conv_active});
        repeat (50) @(posedge ref_clk);
      end
      t0 = tick;
      fire(trg_src[i]);
      wait_end(trg_addr[i][3], 1000);
      chk_rng("trigger cycles", 120, 132, tick - t0);
      wt(trg_addr[i], 32'h2);
    end
    apb(1'b0, 8'h00, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wt(8'h00, 32'h3);
      repeat (30) @(posedge ref_clk);
      {stop_mode, second_idle_mode, first_idle_mode} <= 3'h1 << i;
      repeat (2) @(posedge ref_clk);
      chk("halted", 32'h0, {31'h0, conv_active});
      {stop_mode, second_idle_mode, first_idle_mode} <= 3'h0;
      repeat (200) @(posedge ref_clk);
      rdchk("halt flags", 8'h00, 32'h2);
    end
    // second idle with the run bit set keeps converting
    wt(8'h00, 32'h13);
    second_idle_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("idle run kept", 32'h1, {31'h0, conv_active});
    second_idle_mode <= 1'b0;
    wait_end(1'b0, 1000);
    // two stores into pair 3 with no read between
    wt(8'h04, 32'h3);
    for (int i = 0; i < 2; i++) begin
      wt(8'h00, 32'h3);
      wait_end(1'b0, 1000);
    end
    rdchk("overrun set", 8'h58, 32'hc3);
    rdchk("overrun cleared", 8'h58, 32'hc0);
    // reset while idle puts the mode word back to its default
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdchk("mode after reset", 8'h04, 32'h0);
    results();
  end
endmodule
`default_nettype wire
